// ==== vtr_core.sv ====
// Vector table relocation control with Wishbone register access.
// Assumes a classic Wishbone master and an instruction done strobe.
//
// Our own choices: the Wishbone slave port and the register offsets.
`default_nettype none
`include "vtr_consts.svh"
// Behaviour
// - Select zero: vectors at flash start
// - Select one: vectors at boot section
// - Unlock clears after four cycles or write
// - Block interrupts from unlock until after instruction
// - Unused unlock blocks exactly four cycles
// - Global interrupt enable left untouched
// - Boot vectors, app lock: block in application
// - App vectors, boot lock: block in boot
// - Default reset 0x0000, relocated vectors 0x1C02
// - Boot reset 0x1C00, vectors 0x0002
// - Relocated vector equals boot start plus default
module vtr_core (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write
  input wire logic [3:0] sel_i, // Byte selects
  input wire logic [7:0] adr_i, // Byte address
  input wire logic [31:0] dat_i, // Write data
  output logic [31:0] dat_o, // Read data
  output logic ack_o, // Wishbone ack
  output logic err_o, // Unmapped access
  input wire vtr_pkg::vtr_fuses_t fuses_i, // Fuse and lock straps
  input wire logic [`VTR_PC_W-1:0] pc_i, // Current fetch word
  input wire logic instr_done_i, // Instruction completes
  input wire logic global_ie_i, // Status register I bit
  output vtr_pkg::vtr_addr_t addr_o, // Vector base and reset
  output logic vector_table_select_o, // Select state
  output logic irq_allow_o // Servicing allowed
);
  logic vector_table_select_reg;
  logic hold_reg;
  logic [1:0] post_reg;
  logic unlock_open;
  logic [2:0] unlock_count;
  logic req;
  logic ctrl_hit;
  logic stat_hit;
  logic ctrl_wr;
  logic set_unlock;
  logic sel_write;
  logic [`VTR_PC_W-1:0] boot_base;
  logic in_boot;
  logic lock_block;
  logic seq_block;

  // ------------------------------------------------------------------
  // Boot section base from size fuses
  // ------------------------------------------------------------------
  function automatic logic [`VTR_PC_W-1:0] boot_start(input logic [1:0] sz);
    unique case (sz)
      2'b00: boot_start = `VTR_BOOT_2K;
      2'b01: boot_start = `VTR_BOOT_1K;
      2'b10: boot_start = `VTR_BOOT_512;
      2'b11: boot_start = `VTR_BOOT_256;
    endcase
  endfunction

  assign boot_base = boot_start(fuses_i.boot_size_fuses);
  assign in_boot = (pc_i >= boot_base);

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign ctrl_hit = (adr_i == `VTR_ADDR_MCU_CONTROL);
  assign stat_hit = (adr_i == `VTR_ADDR_STATUS);
  assign ctrl_wr = req && we_i && ctrl_hit && sel_i[0];
  assign set_unlock = ctrl_wr && dat_i[`VTR_BIT_UNLOCK];
  assign sel_write = ctrl_wr && unlock_open && !dat_i[`VTR_BIT_UNLOCK];

  vtr_unlock u_unlock (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(set_unlock),
    .sel_wr_i(sel_write),
    .open_o(unlock_open),
    .count_o(unlock_count)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end
    else
    begin
      ack_o <= req && (ctrl_hit || stat_hit);
      err_o <= req && !(ctrl_hit || stat_hit);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (req && !we_i && ctrl_hit)
      dat_o <= {30'h0000_0000, vector_table_select_reg, unlock_open};
    else if (req && !we_i && stat_hit)
      dat_o <= {20'h0_0000, irq_allow_o, lock_block, in_boot, hold_reg, unlock_count, fuses_i};
    else
      dat_o <= 32'h0000_0000;
  end

  // ------------------------------------------------------------------
  // Select bit
  // ------------------------------------------------------------------
  // locked write ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      vector_table_select_reg <= 1'b0;
    else if (sel_write)
      vector_table_select_reg <= dat_i[`VTR_BIT_SELECT];
  end

  // ------------------------------------------------------------------
  // Sequence blocking
  // ------------------------------------------------------------------
  // hold through next instruction
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      post_reg <= 2'h0;
    else if (sel_write)
      post_reg <= 2'h2;
    else if (instr_done_i && post_reg != 2'h0)
      post_reg <= post_reg - 2'h1;
  end

  // four cycle block
  // Last open cycle not blocked: set cycle already counts as one
  assign seq_block = set_unlock || (unlock_open && unlock_count != 3'h1) || sel_write || (post_reg != 2'h0);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hold_reg <= 1'b0;
    else
      hold_reg <= seq_block;
  end

  assign lock_block = (vector_table_select_reg && fuses_i.app_side_lock_bit && !in_boot)
                   || (!vector_table_select_reg && fuses_i.boot_side_lock_bit && in_boot);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_allow_o <= 1'b0;
    else
      irq_allow_o <= global_ie_i && !seq_block && !lock_block;
  end

  // ------------------------------------------------------------------
  // Addresses
  // ------------------------------------------------------------------
  // vector and reset placement
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_o <= '0;
      vector_table_select_o <= 1'b0;
    end
    else
    begin
      addr_o.vector_base <= vector_table_select_reg ? boot_base + `VTR_VEC_OFFSET
                                                    : `VTR_FLASH_START + `VTR_VEC_OFFSET;
      addr_o.reset_address <= fuses_i.boot_reset_fuse ? `VTR_FLASH_START : boot_base;
      vector_table_select_o <= vector_table_select_reg;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_locked_select: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_wr && !unlock_open) |=> $stable(vector_table_select_reg))
    else $error("select changed without unlock");
  a_block_on_set: assert property (@(posedge clk_i) disable iff (rst_i)
    set_unlock |=> !irq_allow_o)
    else $error("interrupts allowed after unlock set");
  a_block_four: assert property (@(posedge clk_i) disable iff (rst_i)
    (set_unlock && !sel_write && post_reg == 2'h0) ##1 !ctrl_wr [*4] |=> !hold_reg)
    else $error("block outlasted four cycles");
  a_app_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    (vector_table_select_reg && fuses_i.app_side_lock_bit && !in_boot) |=> !irq_allow_o)
    else $error("interrupt in application with lock");
  a_boot_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    (!vector_table_select_reg && fuses_i.boot_side_lock_bit && in_boot) |=> !irq_allow_o)
    else $error("interrupt in boot with lock");
  a_vec_relocated: assert property (@(posedge clk_i) disable iff (rst_i)
    (vector_table_select_reg && fuses_i.boot_size_fuses == 2'b00 && $stable(fuses_i))
    |=> addr_o.vector_base == 13'h1C02)
    else $error("relocated vector base wrong");
  a_vec_default: assert property (@(posedge clk_i) disable iff (rst_i)
    !vector_table_select_reg |=> addr_o.vector_base == 13'h0002)
    else $error("default vector base wrong");
  a_boot_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fuses_i.boot_reset_fuse && fuses_i.boot_size_fuses == 2'b00) |=> addr_o.reset_address == 13'h1C00)
    else $error("boot reset address wrong");
endmodule
`default_nettype wire

// ==== vtr_consts.svh ====
// Constants for the vector table relocation block.
// Assumes inclusion by bare name from the package and design files.
`ifndef VTR_CONSTS_SVH
`define VTR_CONSTS_SVH

// --------------------------------------------------------------------
// Register map (word addresses are byte addresses, 32-bit words)
// --------------------------------------------------------------------
`define VTR_ADDR_MCU_CONTROL 8'h00
`define VTR_ADDR_STATUS 8'h04
`define VTR_ADDR_W 8

// --------------------------------------------------------------------
// Control register fields and reset value
// --------------------------------------------------------------------
`define VTR_BIT_UNLOCK 0
`define VTR_BIT_SELECT 1
`define VTR_CTRL_RESET 8'h00

// --------------------------------------------------------------------
// Unlock window in cycles
// --------------------------------------------------------------------
`define VTR_UNLOCK_CYCLES 3'h4

// --------------------------------------------------------------------
// Program memory word addresses
// --------------------------------------------------------------------
`define VTR_PC_W 13
`define VTR_FLASH_START 13'h0000
`define VTR_VEC_OFFSET 13'h0002
`define VTR_BOOT_2K 13'h1C00
`define VTR_BOOT_1K 13'h1E00
`define VTR_BOOT_512 13'h1F00
`define VTR_BOOT_256 13'h1F80

`endif

// ==== vtr_pkg.sv ====
// Types shared by the vector table relocation block.
// Assumes the constants header sits in the include path.
`default_nettype none
`include "vtr_consts.svh"
package vtr_pkg;
  typedef struct packed {
    logic boot_reset_fuse;
    logic [1:0] boot_size_fuses;
    logic app_side_lock_bit;
    logic boot_side_lock_bit;
  } vtr_fuses_t;
  typedef struct packed {
    logic [`VTR_PC_W-1:0] vector_base;
    logic [`VTR_PC_W-1:0] reset_address;
  } vtr_addr_t;
endpackage
`default_nettype wire

// ==== vtr_unlock.sv ====
// Unlock window timer for vector table select changes.
// Assumes set and write strobes come from the same clock.
`default_nettype none
`include "vtr_consts.svh"
module vtr_unlock (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset
  input wire logic set_i, // Unlock bit written one
  input wire logic sel_wr_i, // Select write in window
  output logic open_o, // Unlock bit state
  output logic [2:0] count_o // Cycles left
);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_o <= 3'h0;
      open_o <= 1'b0;
    end
    else if (sel_wr_i)
    begin
      count_o <= 3'h0;
      open_o <= 1'b0;
    end
    else if (set_i)
    begin
      count_o <= `VTR_UNLOCK_CYCLES;
      open_o <= 1'b1;
    end
    else if (count_o != 3'h0)
    begin
      count_o <= count_o - 3'h1;
      open_o <= (count_o != 3'h1);
    end
  end

  a_unlock_expires: assert property (@(posedge clk_i) disable iff (rst_i)
    (set_i && !sel_wr_i) ##1 !sel_wr_i [*4] |=> !open_o)
    else $error("unlock bit outlived four cycles");
endmodule
`default_nettype wire

// ==== vtr_cpu_model.sv ====
// Processor core stand-in: fetch address, instruction completion, I bit.
// Assumes one system clock and a fetch target set by the bench.
`default_nettype none
`include "vtr_consts.svh"
module vtr_cpu_model (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset
  input wire logic [`VTR_PC_W-1:0] pc_target_i, // Fetch word to sit at
  input wire logic ie_i, // I bit wanted
  output logic [`VTR_PC_W-1:0] pc_o, // Fetch word
  output logic instr_done_o, // Completion pulse
  output logic global_ie_o // Status register I bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_reg <= 2'h0;
      global_ie_o <= 1'b0;
    end
    else
    begin
      phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
      global_ie_o <= ie_i;
    end
  end
  assign instr_done_o = (phase_reg == 2'h2);
  assign pc_o = pc_target_i;
endmodule
`default_nettype wire

// ==== vector_table_relocation_tb_top.sv ====
// Self-checking bench for the vector table relocation block.
// Assumes the core and the processor stand-in share one clock.
`default_nettype none
`include "vtr_consts.svh"
module vector_table_relocation_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ie = 1'b1, e;
  logic ack_o, err_o, sel_o, allow_o, done, gie;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, q, dat_o;
  logic [`VTR_PC_W-1:0] pc_t = 13'h0000, pc, base;
  vtr_pkg::vtr_fuses_t fuses = '0;
  vtr_pkg::vtr_addr_t addr_o;
  int failures = 0, total_checks = 0, low_cnt = 0, last_run = 0, seed = 32'ha6ed;
  always #20 clk_i = ~clk_i;
  vtr_core i_vtr_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(4'h1),
    .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .fuses_i(fuses), .pc_i(pc),
    .instr_done_i(done), .global_ie_i(gie), .addr_o(addr_o), .vector_table_select_o(sel_o),
    .irq_allow_o(allow_o));
  vtr_cpu_model i_vtr_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .pc_target_i(pc_t), .ie_i(ie), .pc_o(pc),
    .instr_done_o(done), .global_ie_o(gie));
  // Length of the latest blocked run
  always @(posedge clk_i)
  begin
    if (!rst_i && allow_o === 1'b0)
      low_cnt++;
    else if (low_cnt != 0)
    begin
      last_run = low_cnt;
      low_cnt = 0;
    end
  end
  function automatic logic [`VTR_PC_W-1:0] boot_base(input logic [1:0] sz);
    case (sz)
      2'h0: return `VTR_BOOT_2K;
      2'h1: return `VTR_BOOT_1K;
      2'h2: return `VTR_BOOT_512;
      default: return `VTR_BOOT_256;
    endcase
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    q = dat_o;
    e = err_o;
    if (n == 20)
      failures++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_allow();
    int n;
    for (n = 0; n < 40 && allow_o !== 1'b1; n++)
      @(posedge clk_i);
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    final_report();
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("vector_base", 32'(addr_o.vector_base), 32'h0000_0002);
    wb(1'b1, 8'h00, 32'h0000_0002);
    wb(1'b0, 8'h00, 32'h0000_0000);
    check("locked select", 32'(q[1]), 32'h0000_0000);
    wb(1'b0, 8'h08, 32'h0000_0000);
    check("unmapped err", 32'(e), 32'h0000_0001);
    $display("Test reset and access done");
    for (int sz = 0; sz < 4; sz++)
    begin
      base = boot_base(2'(sz));
      fuses <= '{boot_reset_fuse: 1'($random(seed)), boot_size_fuses: 2'(sz), default: 1'b0};
      repeat (3) @(posedge clk_i);
      check("reset_address", 32'(addr_o.reset_address), 32'(fuses.boot_reset_fuse ? 13'h0000 : base));
      wb(1'b1, 8'h00, 32'h0000_0001);
      check("blocked", 32'(allow_o), 32'h0000_0000);
      wb(1'b1, 8'h00, 32'h0000_0002);
      wb(1'b0, 8'h00, 32'h0000_0000);
      check("select", 32'(sel_o), 32'h0000_0001);
      check("unlock clear", 32'(q[0]), 32'h0000_0000);
      check("vector_base", 32'(addr_o.vector_base), 32'(base + 13'h0002));
      wait_allow();
      check("release", 32'(allow_o), 32'h0000_0001);
      wb(1'b1, 8'h00, 32'h0000_0001);
      wb(1'b1, 8'h00, 32'h0000_0000);
      repeat (2) @(posedge clk_i);
      check("vector_base", 32'(addr_o.vector_base), 32'h0000_0002);
      wait_allow();
      $display("Test relocation size %0d done", sz);
    end
    wb(1'b1, 8'h00, 32'h0000_0001);
    repeat (6) @(posedge clk_i);
    wb(1'b1, 8'h00, 32'h0000_0002);
    wb(1'b0, 8'h00, 32'h0000_0000);
    check("late select", 32'(q[1]), 32'h0000_0000);
    check("blocked run", 32'(last_run), 32'h0000_0004);
    $display("Test window expiry done");
    fuses <= '{boot_side_lock_bit: 1'b1, default: 1'b0};
    pc_t <= `VTR_BOOT_2K + 13'(($random(seed) & 32'h3FF));
    repeat (3) @(posedge clk_i);
    check("boot lock", 32'(allow_o), 32'h0000_0000);
    pc_t <= 13'(($random(seed) & 32'hFFF));
    repeat (3) @(posedge clk_i);
    check("boot lock app", 32'(allow_o), 32'h0000_0001);
    fuses <= '{app_side_lock_bit: 1'b1, default: 1'b0};
    wb(1'b1, 8'h00, 32'h0000_0001);
    wb(1'b1, 8'h00, 32'h0000_0002);
    wait_allow();
    repeat (3) @(posedge clk_i);
    check("app lock", 32'(allow_o), 32'h0000_0000);
    pc_t <= `VTR_BOOT_2K + 13'h0010;
    repeat (3) @(posedge clk_i);
    check("app lock boot", 32'(allow_o), 32'h0000_0001);
    $display("Test lock bits done");
    final_report();
  end
endmodule
`default_nettype wire
